// ===== src/ime_master.sv
// Master-mode two-wire bus engine with an AHB-Lite register slave.
// Assumes open-drain SCL/SDA resolved outside; pins arrive asynchronously to MCLK.
// Summary of operation
// - After rise interval, sample SCL; if low, pause the high counter until high.
// - Rise setting bounds the drive-high to seen-high delay, keeping SCL rate steady.
// - Bus free and start bit set: send start, set master flag.
// - Start bit in master mode: repeated start after the current byte.
// - After a start, set start-sent flag; event interrupt if enabled.
// - Start-sent clears on status one read then data write; SCL held low.
// - Send one address byte; then set address-sent flag, event interrupt.
// - Address-sent clears on status one read then status two read; SCL held.
// - Address bit zero selects transmit (0) or receive (1); direction flag shows it.
// - Transmitter stretches SCL after address until first data byte is written.
// - Transmitter: acknowledge received sets tx-empty; interrupt with both enables.
// - Tx-empty and no new byte at byte end: byte-finished set, SCL held.
// - Stop bit: send stop, clear tx-empty, byte-finished, master flag.
// - Start, address, first-data and last-byte events hold SCL low until serviced.
// - Receiver drives acknowledge when acknowledge bit set, else non-acknowledge.
// - Each received byte sets rx-not-empty; interrupt with both enables.
// - Rx-not-empty still set at next byte end: byte-finished set, SCL held.
// - Bytes move MSB first, eight bits plus a ninth acknowledge clock.
module ime_master (
  input  wire logic                  MCLK,
  input  wire logic                  RESET_N,
  input  wire logic                  HSEL,
  input  wire logic [ime_pkg::AW-1:0] HADDR,
  input  wire logic [1:0]            HTRANS,
  input  wire logic                  HWRITE,
  input  wire logic [2:0]            HSIZE,
  input  wire logic [ime_pkg::DW-1:0] HWDATA,
  input  wire logic                  HREADY,
  output logic      [ime_pkg::DW-1:0] HRDATA,
  output logic                       HREADYOUT,
  output logic                       HRESP,
  output logic                       IRQ,
  input  wire logic                  SCL_I,
  output logic                       SCL_O,
  output logic                       SCL_OE,
  input  wire logic                  SDA_I,
  output logic                       SDA_O,
  output logic                       SDA_OE
);
  import ime_pkg::*;

  // Bus-side state
  logic          wr_valid_reg, wr_valid_next;
  logic [7:0]    wr_addr_reg, wr_addr_next;
  logic [DW-1:0] hrdata_reg, hrdata_next;
  logic          ready_reg;
  // Engine state
  ime_state_t        state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next, period_reg, period_next;
  logic [RISE_W-1:0] rise_reg, rise_next;
  logic [3:0]        bit_reg, bit_next;
  logic [7:0]        shift_reg, shift_next, dr_reg, dr_next;
  logic dr_full_reg, dr_full_next, start_req_reg, start_req_next, stop_req_reg, stop_req_next;
  logic ack_en_reg, ack_en_next, evt_en_reg, evt_en_next, buf_en_reg, buf_en_next;
  logic sb_reg, sb_next, addr_reg, addr_next, btf_reg, btf_next, txe_reg, txe_next;
  logic rx_not_empty_flag_reg, rx_not_empty_flag_next, msl_reg, msl_next, tra_reg, tra_next, busy_reg, busy_next;
  logic addr_ph_reg, addr_ph_next, sda_prev_reg, sr1_seen_reg, sr1_seen_next;
  logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next, irq_reg, irq_next;
  // Decoded strobes and synchronised pins
  logic       ap, rd_stat1, rd_stat2, rd_data, wr_ctrl, wr_data, wr_period, wr_rise;
  logic [1:0] pins_s;
  logic       scl_s, sda_s, high_done, rx_data;

  // Pin synchroniser
  ime_sync #(.W(2)) u_sync (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .d_in  ({SCL_I, SDA_I}),
    .q     (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Counter step for a released-SCL phase; pauses only after the rise interval
  function automatic logic [CNT_W-1:0] high_step(input logic [CNT_W-1:0] c,
                                                  input logic [RISE_W-1:0] r, input logic scl);
    logic [CNT_W-1:0] rl;
    rl = {{(CNT_W-RISE_W){1'b0}}, r};
    if (c >= rl && !scl)
      high_step = c;
    else
      high_step = c + 12'h001;
  endfunction

  // Address-phase decode and data-phase write strobes
  assign ap        = HSEL && HTRANS[1] && HREADY;
  assign rd_stat1  = ap && !HWRITE && HADDR[7:0] == OFF_STAT1;
  assign rd_stat2  = ap && !HWRITE && HADDR[7:0] == OFF_STAT2;
  assign rd_data   = ap && !HWRITE && HADDR[7:0] == OFF_DATA;
  assign wr_ctrl   = wr_valid_reg && wr_addr_reg == OFF_CTRL;
  assign wr_data   = wr_valid_reg && wr_addr_reg == OFF_DATA;
  assign wr_period = wr_valid_reg && wr_addr_reg == OFF_PERIOD;
  assign wr_rise   = wr_valid_reg && wr_addr_reg == OFF_RISE;
  assign high_done = cnt_reg == period_reg;
  assign rx_data   = !tra_reg && !addr_ph_reg;

  // Bus slave: capture writes, answer reads from the address phase
  always_comb
  begin
    wr_valid_next = ap && HWRITE;
    wr_addr_next  = HADDR[7:0];
    hrdata_next   = hrdata_reg;
    if (ap && !HWRITE)
    begin
      hrdata_next = '0;
      unique case (HADDR[7:0])
        OFF_CTRL:
        begin
          hrdata_next[CTRL_START]  = start_req_reg;
          hrdata_next[CTRL_STOP]   = stop_req_reg;
          hrdata_next[CTRL_ACK]    = ack_en_reg;
          hrdata_next[CTRL_EVT_EN] = evt_en_reg;
          hrdata_next[CTRL_BUF_EN] = buf_en_reg;
        end
        OFF_DATA:   hrdata_next[7:0] = dr_reg;
        OFF_STAT1:
        begin
          hrdata_next[ST1_SB]   = sb_reg;
          hrdata_next[ST1_ADDR] = addr_reg;
          hrdata_next[ST1_BTF]  = btf_reg;
          hrdata_next[ST1_RX_NOT_EMPTY_FLAG] = rx_not_empty_flag_reg;
          hrdata_next[ST1_TXE]  = txe_reg;
        end
        OFF_STAT2:
        begin
          hrdata_next[ST2_MSL]  = msl_reg;
          hrdata_next[ST2_BUSY] = busy_reg;
          hrdata_next[ST2_TRA]  = tra_reg;
        end
        OFF_PERIOD: hrdata_next[CNT_W-1:0] = period_reg;
        OFF_RISE:   hrdata_next[RISE_W-1:0] = rise_reg;
        default:    hrdata_next = '0; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      wr_valid_reg <= 1'b0;
      wr_addr_reg  <= 8'h00;
      hrdata_reg   <= '0;
      ready_reg    <= 1'b0;
    end
    else
    begin
      wr_valid_reg <= wr_valid_next;
      wr_addr_reg  <= wr_addr_next;
      hrdata_reg   <= hrdata_next;
      ready_reg    <= 1'b1;
    end
  end

  // Engine: software access effects first, hardware events after so sets win
  always_comb
  begin
    state_next = state_reg;   cnt_next = cnt_reg;       bit_next = bit_reg;
    shift_next = shift_reg;   dr_next = dr_reg;         dr_full_next = dr_full_reg;
    start_req_next = start_req_reg; stop_req_next = stop_req_reg;
    ack_en_next = ack_en_reg; evt_en_next = evt_en_reg; buf_en_next = buf_en_reg;
    sb_next = sb_reg;         addr_next = addr_reg;     btf_next = btf_reg;
    txe_next = txe_reg;       rx_not_empty_flag_next = rx_not_empty_flag_reg;     msl_next = msl_reg;
    tra_next = tra_reg;       addr_ph_next = addr_ph_reg; sda_oe_next = sda_oe_reg;
    period_next = wr_period ? HWDATA[CNT_W-1:0] : period_reg;
    rise_next   = wr_rise ? HWDATA[RISE_W-1:0] : rise_reg;
    busy_next   = busy_reg;
    if (scl_s && sda_prev_reg && !sda_s)
      busy_next = 1'b1;
    else if (scl_s && !sda_prev_reg && sda_s)
      busy_next = 1'b0;
    sr1_seen_next = sr1_seen_reg;
    if (rd_stat1)
      sr1_seen_next = 1'b1;
    else if (wr_data || rd_data || rd_stat2)
      sr1_seen_next = 1'b0;
    if (wr_ctrl)
    begin
      start_req_next = start_req_reg || HWDATA[CTRL_START];
      stop_req_next  = stop_req_reg || HWDATA[CTRL_STOP];
      ack_en_next    = HWDATA[CTRL_ACK];
      evt_en_next    = HWDATA[CTRL_EVT_EN];
      buf_en_next    = HWDATA[CTRL_BUF_EN];
    end
    if (wr_data)
    begin
      dr_next      = HWDATA[7:0];
      dr_full_next = 1'b1;
      txe_next     = 1'b0;
      if (sb_reg && sr1_seen_reg)
        sb_next = 1'b0;
      if (btf_reg && tra_reg && sr1_seen_reg)
        btf_next = 1'b0;
    end
    if (rd_stat2 && addr_reg && sr1_seen_reg)
      addr_next = 1'b0;
    if (rd_data)
    begin
      if (btf_reg && !tra_reg && sr1_seen_reg)
      begin
        dr_next  = shift_reg;
        btf_next = 1'b0;
      end
      else
        rx_not_empty_flag_next = 1'b0;
    end
    cnt_next = cnt_reg + 12'h001;
    unique case (state_reg)
      S_IDLE:
      begin
        cnt_next = '0;
        if (start_req_reg && !busy_reg && scl_s && sda_s)
        begin
          state_next = S_ST_HOLD;
          msl_next = 1'b1;
          sda_oe_next = 1'b1;
        end
      end
      S_ST_HOLD:
        if (high_done)
        begin
          state_next = S_WAIT;
          cnt_next = '0;
          sb_next = 1'b1;
          start_req_next = 1'b0;
          addr_ph_next = 1'b1;
          tra_next = 1'b0;
        end
      S_WAIT:
      begin
        cnt_next = '0;
        if (sb_reg || addr_reg)
          state_next = S_WAIT;
        else if (stop_req_reg)
        begin
          state_next = S_SP_LOW;
          stop_req_next = 1'b0;
          sda_oe_next = 1'b1;
          txe_next = 1'b0;
          btf_next = 1'b0;
          msl_next = 1'b0;
        end
        else if (start_req_reg)
        begin
          state_next = S_RS_LOW;
          sda_oe_next = 1'b0;
        end
        else if (btf_reg)
          state_next = S_WAIT;
        else if (addr_ph_reg || tra_reg)
        begin
          if (dr_full_reg)
          begin
            state_next = S_BLOW;
            shift_next = dr_reg;
            dr_full_next = 1'b0;
            txe_next = !addr_ph_reg;
            bit_next = 4'h0;
          end
        end
        else
        begin
          state_next = S_BLOW;
          bit_next = 4'h0;
        end
      end
      S_BLOW:
      begin
        if (cnt_reg == (period_reg >> 1))
        begin
          if (bit_reg == ACK_SLOT)
            sda_oe_next = rx_data && ack_en_reg;
          else
            sda_oe_next = (tra_reg || addr_ph_reg) && !shift_reg[7];
        end
        if (high_done)
        begin
          state_next = S_BHIGH;
          cnt_next = '0;
        end
      end
      S_BHIGH:
      begin
        cnt_next = high_step(cnt_reg, rise_reg, scl_s);
        if (high_done)
        begin
          cnt_next = '0;
          if (bit_reg != ACK_SLOT)
          begin
            state_next = S_BLOW;
            shift_next = {shift_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end
          else
          begin
            state_next = S_WAIT;
            if (addr_ph_reg)
            begin
              addr_ph_next = 1'b0;
              addr_next = 1'b1;
              tra_next = !shift_reg[0];
              txe_next = !shift_reg[0];
            end
            else if (tra_reg)
            begin
              if (!sda_s)
              begin
                txe_next = 1'b1;
                if (dr_full_reg && !stop_req_reg && !start_req_reg)
                begin
                  state_next = S_BLOW;
                  shift_next = dr_reg;
                  dr_full_next = 1'b0;
                  bit_next = 4'h0;
                end
                else if (!dr_full_reg)
                  btf_next = 1'b1;
              end
            end
            else if (!rx_not_empty_flag_next) // A data read in this cycle frees the register
            begin
              dr_next = shift_reg;
              rx_not_empty_flag_next = 1'b1;
            end
            else
              btf_next = 1'b1;
          end
        end
      end
      S_SP_LOW:
        if (high_done)
        begin
          state_next = S_SP_HIGH;
          cnt_next = '0;
        end
      S_SP_HIGH:
      begin
        cnt_next = high_step(cnt_reg, rise_reg, scl_s);
        if (high_done)
        begin
          state_next = S_SP_DONE;
          cnt_next = '0;
          sda_oe_next = 1'b0;
        end
      end
      S_SP_DONE:
        if (high_done)
          state_next = S_IDLE;
      S_RS_LOW:
        if (high_done)
        begin
          state_next = S_RS_HIGH;
          cnt_next = '0;
        end
      S_RS_HIGH:
      begin
        cnt_next = high_step(cnt_reg, rise_reg, scl_s);
        if (high_done)
        begin
          state_next = S_ST_HOLD;
          cnt_next = '0;
          sda_oe_next = 1'b1;
        end
      end
      default:
        state_next = S_IDLE;
    endcase
    scl_oe_next = state_next inside {S_WAIT, S_BLOW, S_SP_LOW, S_RS_LOW};
    irq_next = evt_en_next && (sb_next || addr_next || btf_next || (buf_en_next && (txe_next || rx_not_empty_flag_next)));
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      state_reg <= S_IDLE;    cnt_reg <= '0;            bit_reg <= 4'h0;
      shift_reg <= 8'h00;     dr_reg <= 8'h00;          dr_full_reg <= 1'b0;
      start_req_reg <= 1'b0;  stop_req_reg <= 1'b0;     ack_en_reg <= 1'b0;
      evt_en_reg <= 1'b0;     buf_en_reg <= 1'b0;       sb_reg <= 1'b0;
      addr_reg <= 1'b0;       btf_reg <= 1'b0;          txe_reg <= 1'b0;
      rx_not_empty_flag_reg <= 1'b0;       msl_reg <= 1'b0;          tra_reg <= 1'b0;
      busy_reg <= 1'b0;       addr_ph_reg <= 1'b0;      sda_prev_reg <= 1'b1;
      sr1_seen_reg <= 1'b0;   scl_oe_reg <= 1'b0;       sda_oe_reg <= 1'b0;
      irq_reg <= 1'b0;        period_reg <= PERIOD_RST; rise_reg <= RISE_RST;
    end
    else
    begin
      state_reg <= state_next; cnt_reg <= cnt_next;     bit_reg <= bit_next;
      shift_reg <= shift_next; dr_reg <= dr_next;       dr_full_reg <= dr_full_next;
      start_req_reg <= start_req_next; stop_req_reg <= stop_req_next; ack_en_reg <= ack_en_next;
      evt_en_reg <= evt_en_next; buf_en_reg <= buf_en_next; sb_reg <= sb_next;
      addr_reg <= addr_next;   btf_reg <= btf_next;     txe_reg <= txe_next;
      rx_not_empty_flag_reg <= rx_not_empty_flag_next;   msl_reg <= msl_next;     tra_reg <= tra_next;
      busy_reg <= busy_next;   addr_ph_reg <= addr_ph_next; sda_prev_reg <= sda_s;
      sr1_seen_reg <= sr1_seen_next; scl_oe_reg <= scl_oe_next; sda_oe_reg <= sda_oe_next;
      irq_reg <= irq_next;     period_reg <= period_next; rise_reg <= rise_next;
    end
  end

  // Outputs straight from flops; pins only ever pull low
  assign HRDATA    = hrdata_reg;
  assign HREADYOUT = ready_reg;
  assign HRESP     = 1'b0 & ready_reg;
  assign IRQ       = irq_reg;
  assign SCL_O     = 1'b0 & scl_oe_reg;
  assign SDA_O     = 1'b0 & sda_oe_reg;
  assign SCL_OE    = scl_oe_reg;
  assign SDA_OE    = sda_oe_reg;

  // Checks on the engine
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  a_high_pause: assert property ((state_reg == S_BHIGH && cnt_reg >= {6'h00, rise_reg} && !scl_s)
    |=> cnt_reg == $past(cnt_reg)) else $error("high counter ran while SCL low");
  a_rise_count: assert property ((state_reg == S_BHIGH && cnt_reg < {6'h00, rise_reg} && !high_done)
    |=> cnt_reg == $past(cnt_reg) + 12'h001) else $error("counter paused inside rise interval");
  a_start_go: assert property ((state_reg == S_IDLE && start_req_reg && !busy_reg && scl_s && sda_s)
    |=> msl_reg && state_reg == S_ST_HOLD ##1 sda_oe_reg) else $error("start not issued");
  a_sb_set: assert property ((state_reg == S_ST_HOLD && high_done) |=> sb_reg && scl_oe_reg)
    else $error("start-sent flag missing");
  a_sb_clear: assert property ((sb_reg && wr_data && sr1_seen_reg) |=> !sb_reg)
    else $error("start-sent did not clear");
  a_addr_clear: assert property ((addr_reg && rd_stat2 && sr1_seen_reg) |=> !addr_reg)
    else $error("address-sent did not clear");
  a_addr_dir: assert property ($rose(addr_reg) |-> tra_reg == !shift_reg[0])
    else $error("direction does not match address bit");
  a_hold_low: assert property ((state_reg == S_WAIT && (sb_reg || addr_reg || btf_reg)) |=> scl_oe_reg)
    else $error("SCL released during held event");
  a_tx_btf: assert property ((state_reg == S_BHIGH && high_done && bit_reg == ACK_SLOT && tra_reg
    && !addr_ph_reg && !sda_s && !dr_full_reg) |=> txe_reg && btf_reg) else $error("tx byte end flags");
  a_rx_flags: assert property ((state_reg == S_BHIGH && high_done && bit_reg == ACK_SLOT && rx_data)
    |=> rx_not_empty_flag_reg && (btf_reg == ($past(rx_not_empty_flag_reg) && !$past(rd_data)))) else $error("rx byte end flags");
  a_ack_drive: assert property ((state_reg == S_BLOW && cnt_reg == (period_reg >> 1) && bit_reg == ACK_SLOT
    && rx_data) |=> sda_oe_reg == $past(ack_en_reg)) else $error("wrong acknowledge level");
  a_stop_clear: assert property ((state_reg == S_WAIT && !sb_reg && !addr_reg && stop_req_reg)
    |=> !msl_reg && !txe_reg && !btf_reg && state_reg == S_SP_LOW) else $error("stop did not clear");
  c_start: cover property (state_reg == S_ST_HOLD ##1 sb_reg);
  c_rx_byte: cover property ($rose(rx_not_empty_flag_reg) && msl_reg);
  c_stop: cover property (state_reg == S_SP_DONE ##1 state_reg == S_IDLE);
endmodule

// ===== pkg/ime_pkg.sv
// Constants, register map and state encoding of the two-wire master engine.
// Assumes a 32-bit AHB-Lite register bus and open-drain SCL and SDA pins.
package ime_pkg;
  localparam int DW         = 32;
  localparam int AW         = 32;
  localparam int CNT_W      = 12;
  localparam int RISE_W     = 6;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_DATA   = 8'h04;
  localparam logic [7:0] OFF_STAT1  = 8'h08;
  localparam logic [7:0] OFF_STAT2  = 8'h0C;
  localparam logic [7:0] OFF_PERIOD = 8'h10;
  localparam logic [7:0] OFF_RISE   = 8'h14;
  // Control register fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_ACK    = 2;
  localparam int CTRL_EVT_EN = 3;
  localparam int CTRL_BUF_EN = 4;
  // Status register one fields
  localparam int ST1_SB      = 0;
  localparam int ST1_ADDR    = 1;
  localparam int ST1_BTF     = 2;
  localparam int ST1_RX_NOT_EMPTY_FLAG    = 6;
  localparam int ST1_TXE     = 7;
  // Status register two fields
  localparam int ST2_MSL     = 0;
  localparam int ST2_BUSY    = 1;
  localparam int ST2_TRA     = 2;
  // Reset values and bit counts
  localparam logic [CNT_W-1:0]  PERIOD_RST = 12'h01F;
  localparam logic [RISE_W-1:0] RISE_RST   = 6'h04;
  localparam logic [3:0]        ACK_SLOT   = 4'h8;
  // Master sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_ST_HOLD, S_WAIT, S_BLOW, S_BHIGH, S_SP_LOW, S_SP_HIGH, S_SP_DONE, S_RS_LOW, S_RS_HIGH
  } ime_state_t;
endpackage

// ===== src/ime_sync.sv
// Three-stage synchroniser for pin levels entering the MCLK domain.
// Assumes idle-high open-drain lines; the output moves once stages two and three agree.
module ime_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic [W-1:0] q_next;

  // Take each bit only when the last two stages agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
      q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
  end

  // Stage registers, reset to the idle-high level
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      q_reg  <= '1;
    end
    else
    begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;
endmodule

// ===== tb/ime_slave.sv
// Slave model: acks the address and every written byte, serves 5A, 5B, ... after each address.
// Assumes pulled-up wires; the model changes SDA 20 ns after SCL falls.
module ime_slave (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic slow,
  output logic      scl_oe,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  sh, tx;
  logic [31:0] rx, acks;
  logic        act, adr, rd;
  int          cnt;

  initial
  begin
    {scl_oe, sda_oe, act, rd, rx, acks} = '0;
  end
  // Start or restart opens a new address byte
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      {act, adr, rd, cnt, tx} = {2'b11, 1'b0, 32'd0, 8'h5A};
    end
  // Stop ends the frame
  always @(posedge sda)
    if (scl === 1'b1)
      act = 1'b0;
  // Shift in MSB first; the ninth rise in read mode carries the master's answer
  always @(posedge scl)
    if (act)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      else if (rd && !adr)
      begin
        acks = {acks[30:0], !sda};
        act = !sda;
      end
      cnt++;
    end
  // Ack slot and read bits on each SCL fall; optional stretch on the first fall of each byte
  always @(negedge scl)
    if (act)
    begin
      if (cnt == 8)
      begin
        if (adr)
          rd = sh[0];
        else if (!rd)
          rx = {rx[23:0], sh};
        else
          tx = tx + 8'h1;
        sda_oe <= #20 adr || !rd;
      end
      else
      begin
        if (cnt == 9)
        begin
          cnt = 0;
          adr = 1'b0;
        end
        sda_oe <= #20 rd && !tx[7 - cnt];
        if (cnt == 0 && slow)
        begin
          scl_oe = 1'b1;
          #300;
          scl_oe = 1'b0;
        end
      end
    end
endmodule

// ===== tb/tb.sv
// Bench: an AHB-Lite master drives the engine against the slave model.
// Assumes zero-wait register bus and pulled-up SCL and SDA wires.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ime_pkg::*;
  logic        mclk, rst_n, hsel, hwrite, slow;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, q, hrdata;
  logic        hreadyout, hresp, irq, scl_o, scl_oe, sda_o, sda_oe, s_scl_oe, s_sda_oe;
  wire         scl = !scl_oe && !s_scl_oe;
  wire         sda = !sda_oe && !s_sda_oe;
  int          fail_count, check_count;

  ime_master dut (.MCLK(mclk), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq), .SCL_I(scl), .SCL_O(scl_o),
    .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe));
  ime_slave slv (.scl(scl), .sda(sda), .slow(slow), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic give_verdict;
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic timeout;
    fail_count++;
    give_verdict;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Wait for ready at a rising edge, bounded
  task automatic rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n == 20)
      timeout;
  endtask

  // One single word transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, a, 32'h0);
      n++;
    end while (q[b] !== v && n < 3000);
    if (n == 3000)
      timeout;
  endtask

  // Start (when ctl is non-zero), address byte, address-sent clear
  task automatic open(input logic [7:0] ab, input logic [31:0] ctl);
    if (ctl != 0)
      bus(1'b1, OFF_CTRL, ctl);
    poll(OFF_STAT1, ST1_SB, 1'b1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFF_DATA, {24'h0, ab});
    poll(OFF_STAT1, ST1_ADDR, 1'b1);
    chk({31'h0, q[ST1_SB]}, 32'h0);
    bus(1'b0, OFF_STAT2, 32'h0);
    chk(q, {29'h0, !ab[0], 2'h3});
    bus(1'b0, OFF_STAT1, 32'h0);
    chk({31'h0, q[ST1_ADDR]}, 32'h0);
  endtask

  task automatic regs_after_reset;
    bus(1'b0, OFF_PERIOD, 32'h0);
    chk(q, {20'h0, PERIOD_RST});
    bus(1'b0, OFF_RISE, 32'h0);
    chk(q, {26'h0, RISE_RST});
    bus(1'b1, 8'h18, 32'hFFFFFFFF);
    bus(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, OFF_PERIOD, 32'h7);
    bus(1'b1, OFF_RISE, 32'h5);
    bus(1'b0, OFF_STAT2, 32'h0);
    chk(q, 32'h0);
    chk({29'h0, hresp, scl_o, sda_o}, 32'h0);
  endtask

  task automatic tx_two;
    open(8'hA4, 32'h9);
    bus(1'b1, OFF_DATA, 32'h3C);
    poll(OFF_STAT1, ST1_TXE, 1'b1);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFF_DATA, 32'hC5);
    poll(OFF_STAT1, ST1_BTF, 1'b1);
    bus(1'b1, OFF_CTRL, 32'hA);
    poll(OFF_STAT2, ST2_MSL, 1'b0);
    bus(1'b0, OFF_STAT1, 32'h0);
    chk(q, 32'h0);
    chk(slv.rx, 32'h3CC5);
  endtask

  task automatic rx_three;
    open(8'hA5, 32'hD);
    poll(OFF_STAT1, ST1_BTF, 1'b1);
    bus(1'b1, OFF_CTRL, 32'h8);
    bus(1'b0, OFF_DATA, 32'h0);
    chk(q, 32'h5A);
    bus(1'b1, OFF_CTRL, 32'h19);
    bus(1'b0, OFF_STAT1, 32'h0);
    bus(1'b0, OFF_DATA, 32'h0);
    chk(q, 32'h5B);
    poll(OFF_STAT1, ST1_RX_NOT_EMPTY_FLAG, 1'b1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, OFF_DATA, 32'h0);
    chk(q, 32'h5C);
    open(8'hA5, 32'h0);
    bus(1'b1, OFF_CTRL, 32'hA);
    poll(OFF_STAT1, ST1_RX_NOT_EMPTY_FLAG, 1'b1);
    bus(1'b0, OFF_DATA, 32'h0);
    chk(q, 32'h5A);
    poll(OFF_STAT2, ST2_MSL, 1'b0);
    chk(slv.acks, 32'hC);
  endtask

  initial
  begin
    {rst_n, hsel, hwrite, slow, htrans, haddr, hwdata} = '0;
    fail_count = 0;
    check_count = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    regs_after_reset;
    tx_two;
    slow <= 1'b1;
    rx_three;
    give_verdict;
  end
endmodule
